// ==== shared/msc_pkg.sv ====
// Purpose: Constants for the monitor sequence control register bank
// Assumes: 8-bit register data, byte addresses as printed
// Notes:   Times in ns; cycle counts derived from the 50 MHz clock
package msc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_HF_DEBOUNCE = 8'h94;
  localparam logic [7:0] ADDR_LF_CUTOFF   = 8'h95;
  localparam logic [7:0] ADDR_CONTROL     = 8'h9F;
  localparam logic [7:0] ADDR_REC_CTL     = 8'hA0;
  localparam logic [7:0] ADDR_AMSK_UP     = 8'hA1;
  localparam logic [7:0] ADDR_AMSK_DOWN   = 8'hA2;
  localparam logic [7:0] ADDR_AMSK_WAKE   = 8'hA3;
  localparam logic [7:0] ADDR_AMSK_DOZE   = 8'hA4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_HF_DEBOUNCE = 8'h00;
  localparam logic [7:0] RST_LF_CUTOFF   = 8'h14;
  localparam logic [7:0] RST_CONTROL     = 8'h02;
  localparam logic [7:0] RST_AMSK        = 8'hFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OV_SETTLE_LSB = 4;
  localparam int SELFTEST_BIT  = 7;
  localparam int MAN_RESET_BIT = 5;
  localparam int LOG_TRIG_BIT  = 7;
  localparam int SEQ_SEL_LSB   = 5;
  localparam int TS_REL_BIT    = 4;
  localparam logic [7:0] CUTOFF_WMASK  = 8'h07;
  localparam logic [7:0] CONTROL_WMASK = 8'hE7;
  localparam logic [3:0] DEB_MAX_CODE  = 4'hA;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS      = 20;
  localparam int DEB_BASE_NS = 100;
  localparam int DEB_BASE_CYC =
    (DEB_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOUT_STEP_NS = 1000000;
  localparam int TOUT_STEP_CYC = TOUT_STEP_NS / CLK_NS;
  localparam int DELAY_W = 24;

  // Reset delay table, ns per code 0..7
  localparam int RDLY_NS [8] = '{200000, 1000000, 10000000, 16000000,
                                 20000000, 70000000, 100000000,
                                 200000000};

  typedef enum logic [1:0] {
    SEQ_POWER_UP, SEQ_POWER_DOWN, SEQ_WAKE, SEQ_DOZE
  } msc_seq_t;

endpackage : msc_pkg

// ==== design/msc_regs.sv ====
// Purpose: Monitor sequence control register bank with auto-masks
// Assumes: Serial host decoded elsewhere into wr_en/rd address strobes
// Notes:   Comparators and log datapath sit outside this block
//
// How it works
// - Overvoltage result asserts only after stable for bits 7:4 time.
// - Undervoltage same with bits 3:0; doubles per code, caps 102.4us.
// - Cutoff code bits 2:0 selects 250Hz..4kHz; 0,1,7 invalid.
// - Cutoff register also routes fast faults onto reset output.
// - Writing 1 to control bit 7 enters self test.
// - Control bit 5 set holds reset output asserted.
// - Control bits 2:0 pick reset delay 200us to 200ms.
// - Writing rec bit 7 starts recording; reads back zero.
// - Bits 6:5 choose which activate or sleep edge is recorded.
// - Bit 4 releases timestamp, clears ready and lost flags.
// - Bit 3 releases power-up log and clears its flags.
// - Bit 2 releases power-down log and clears its flags.
// - Bit 1 releases wake log and clears its flags.
// - Bit 0 releases doze log and clears its flags.
// - Activate rise masks enables of channels set in power-up mask.
// - Activate fall masks channels set in power-down mask.
// - Sleep rise masks channels set in wake mask.
// - Sleep fall masks channels set in doze mask.
// - Masks release after timeout, programmed in 1ms steps, 0 = 1ms.
`timescale 1ns/1ps
module msc_regs
  import msc_pkg::*;
#(
  parameter int NCH          = 8,
  parameter int TOUT_STEP    = TOUT_STEP_CYC,
  parameter int RDLY_SCALE   = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic             wr_en,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  output logic      [7:0]       rdata,
  // Sequence timeout and overwrite config from neighbours
  input  wire logic [15:0]      seq_timeout_ms,
  input  wire logic             timestamp_overwrite_allow,
  input  wire logic             log_overwrite_allow,
  // Pins
  input  wire logic             activate_input,
  input  wire logic             sleep_input,
  // Fast comparators, channel 8
  input  wire logic             ov_raw,
  input  wire logic             uv_raw,
  input  wire logic             ov_fault_any,
  // Per-channel interrupt enables before masking
  input  wire logic [NCH-1:0]   slow_under_irq_enable,
  input  wire logic [NCH-1:0]   fast_under_irq_enable,
  input  wire logic [NCH-1:0]   fast_over_irq_enable,
  // Gated outputs
  output logic      [NCH-1:0]   slow_under_irq_gated,
  output logic      [NCH-1:0]   fast_under_irq_gated,
  output logic      [NCH-1:0]   fast_over_irq_gated,
  output logic      [NCH-1:0]   transition_masks,
  // Filtered comparator results
  output logic                  ov_filtered,
  output logic                  uv_filtered,
  // Control outputs
  output logic      [2:0]       slow_path_cutoff,
  output logic                  fast_fault_to_reset,
  output logic                  self_test_entry,
  output logic                  reset_out,
  output logic      [2:0]       reset_delay_sel,
  output logic                  logging_trigger,
  output msc_seq_t              recorded_transition_select,
  output logic                  timestamp_release,
  output logic      [3:0]       log_release
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]     fast_path_filter;
    logic [7:0]     cutoff;
    logic [7:0]     control;
    msc_seq_t       seq_sel;
    logic [3:0][7:0] amsk;
    logic           act_q;
    logic           slp_q;
    logic [NCH-1:0] masked;
    logic           tout_run;
    logic [15:0]    tout_ms;
    logic [31:0]    tout_cyc;
    logic           ov_q;
    logic           uv_q;
    logic [15:0]    ov_cnt;
    logic [15:0]    uv_cnt;
    logic           ov_out;
    logic           uv_out;
    logic           rst_hold;
    logic [31:0]    rdly_cnt;
    logic           start_p;
    logic           ts_p;
    logic [3:0]     log_p;
    logic           bist_p;
  } msc_state_t;

  msc_state_t s_reg, s_next;

  logic act_rise, act_fall, slp_rise, slp_fall;
  logic [15:0] ov_need, uv_need;
  logic [31:0] rdly_need;

  // Debounce cycles: base doubled per code, capped at the top code
  function automatic logic [15:0] deb_cycles(input logic [3:0] code);
    logic [3:0] c;
    c = (code > DEB_MAX_CODE) ? DEB_MAX_CODE : code;
    return 16'(DEB_BASE_CYC) << c;
  endfunction : deb_cycles

  always_comb begin
    ov_need   = deb_cycles(s_reg.fast_path_filter[7:4]);
    uv_need   = deb_cycles(s_reg.fast_path_filter[3:0]);
    rdly_need = 32'((RDLY_NS[s_reg.control[2:0]] / CLK_NS) / RDLY_SCALE);
    act_rise  = activate_input & ~s_reg.act_q;
    act_fall  = ~activate_input & s_reg.act_q;
    slp_rise  = sleep_input & ~s_reg.slp_q;
    slp_fall  = ~sleep_input & s_reg.slp_q;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next         = s_reg;
    s_next.start_p = 1'b0;
    s_next.ts_p    = 1'b0;
    s_next.log_p   = 4'h0;
    s_next.bist_p  = 1'b0;
    s_next.act_q   = activate_input;
    s_next.slp_q   = sleep_input;

    if (wr_en) begin
      unique case (addr)
        ADDR_HF_DEBOUNCE: s_next.fast_path_filter = wdata;
        // reserved bits read-only, keep reset pattern
        ADDR_LF_CUTOFF: s_next.cutoff = (wdata & CUTOFF_WMASK)
                                      | (RST_LF_CUTOFF & ~CUTOFF_WMASK);
        ADDR_CONTROL: begin
          s_next.control = wdata & CONTROL_WMASK;
          s_next.bist_p  = wdata[SELFTEST_BIT];
        end
        ADDR_REC_CTL: begin
          s_next.seq_sel = msc_seq_t'(wdata[SEQ_SEL_LSB +: 2]);
          s_next.start_p = wdata[LOG_TRIG_BIT];
          s_next.ts_p = wdata[TS_REL_BIT] & ~timestamp_overwrite_allow;
          s_next.log_p = wdata[3:0] & {4{~log_overwrite_allow}};
        end
        ADDR_AMSK_UP:   s_next.amsk[0] = wdata;
        ADDR_AMSK_DOWN: s_next.amsk[1] = wdata;
        ADDR_AMSK_WAKE: s_next.amsk[2] = wdata;
        ADDR_AMSK_DOZE: s_next.amsk[3] = wdata;
        default: ;
      endcase
    end

    if (act_rise | act_fall | slp_rise | slp_fall) begin
      s_next.masked = s_reg.masked
        | (act_rise ? s_reg.amsk[0][NCH-1:0] : '0)
        | (act_fall ? s_reg.amsk[1][NCH-1:0] : '0)
        | (slp_rise ? s_reg.amsk[2][NCH-1:0] : '0)
        | (slp_fall ? s_reg.amsk[3][NCH-1:0] : '0);
      s_next.tout_run = 1'b1;
      s_next.tout_ms  = '0;
      s_next.tout_cyc = '0;
    end else if (s_reg.tout_run) begin
      if (s_reg.tout_cyc == 32'(TOUT_STEP - 1)) begin
        s_next.tout_cyc = '0;
        if (s_reg.tout_ms >= seq_timeout_ms) begin
          s_next.tout_run = 1'b0;
          s_next.masked   = '0;
        end else begin
          s_next.tout_ms = s_reg.tout_ms + 16'h0001;
        end
      end else begin
        s_next.tout_cyc = s_reg.tout_cyc + 32'h0000_0001;
      end
    end

    s_next.ov_q = ov_raw;
    if (ov_raw != s_reg.ov_q) begin
      s_next.ov_cnt = '0;
    end else if (s_reg.ov_cnt < ov_need) begin
      s_next.ov_cnt = s_reg.ov_cnt + 16'h0001;
    end else begin
      s_next.ov_out = s_reg.ov_q;
    end
    s_next.uv_q = uv_raw;
    if (uv_raw != s_reg.uv_q) begin
      s_next.uv_cnt = '0;
    end else if (s_reg.uv_cnt < uv_need) begin
      s_next.uv_cnt = s_reg.uv_cnt + 16'h0001;
    end else begin
      s_next.uv_out = s_reg.uv_q;
    end

    if (s_reg.control[MAN_RESET_BIT]) begin
      s_next.rst_hold = 1'b1;
      s_next.rdly_cnt = '0;
    end else if (s_reg.rst_hold) begin
      if (s_reg.rdly_cnt >= rdly_need) begin
        s_next.rst_hold = 1'b0;
      end else begin
        s_next.rdly_cnt = s_reg.rdly_cnt + 32'h0000_0001;
      end
    end

    if (!rstn) begin
      s_next = '0;
      s_next.fast_path_filter = RST_HF_DEBOUNCE;
      s_next.cutoff  = RST_LF_CUTOFF;
      s_next.control = RST_CONTROL;
      s_next.amsk    = {4{RST_AMSK}};
      // Track pin levels so a high pin gives no false edge after reset
      s_next.act_q   = activate_input;
      s_next.slp_q   = sleep_input;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_gate
      assign slow_under_irq_gated[g] = slow_under_irq_enable[g]
                                       & ~s_reg.masked[g];
      assign fast_under_irq_gated[g] = fast_under_irq_enable[g]
                                       & ~s_reg.masked[g];
      assign fast_over_irq_gated[g]  = fast_over_irq_enable[g]
                                       & ~s_reg.masked[g];
    end
  endgenerate

  assign transition_masks = s_reg.masked;
  assign ov_filtered      = s_reg.ov_out;
  assign uv_filtered      = s_reg.uv_out;
  assign slow_path_cutoff = s_reg.cutoff[2:0];
  // valid cutoff code enables fault routing
  assign fast_fault_to_reset = (s_reg.cutoff[2:0] >= 3'h2)
                               && (s_reg.cutoff[2:0] != 3'h7);
  assign self_test_entry  = s_reg.bist_p;
  assign reset_out        = s_reg.rst_hold
                            | (fast_fault_to_reset & ov_fault_any);
  assign reset_delay_sel  = s_reg.control[2:0];
  assign logging_trigger  = s_reg.start_p;
  assign recorded_transition_select = s_reg.seq_sel;
  assign timestamp_release = s_reg.ts_p;
  assign log_release      = s_reg.log_p;

  // Read mux; trigger and release bits always read zero
  always_comb begin
    unique case (addr)
      ADDR_HF_DEBOUNCE: rdata = s_reg.fast_path_filter;
      ADDR_LF_CUTOFF:   rdata = s_reg.cutoff;
      ADDR_CONTROL:     rdata = {1'b0, s_reg.control[6:0]};
      ADDR_REC_CTL:     rdata = {1'b0, s_reg.seq_sel, 5'h00};
      ADDR_AMSK_UP:     rdata = s_reg.amsk[0];
      ADDR_AMSK_DOWN:   rdata = s_reg.amsk[1];
      ADDR_AMSK_WAKE:   rdata = s_reg.amsk[2];
      ADDR_AMSK_DOZE:   rdata = s_reg.amsk[3];
      default:          rdata = 8'h00;
    endcase
  end

endmodule : msc_regs

// ==== tb/msc_regs_sva.sv ====
// Purpose: Port-level checks for the sequence control register bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind; sees top ports only
`timescale 1ns/1ps
module msc_regs_sva
  import msc_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           rstn,
  // Register port
  input wire logic           wr_en,
  input wire logic [7:0]     addr,
  input wire logic [7:0]     wdata,
  input wire logic [7:0]     rdata,
  // Config and pins
  input wire logic           timestamp_overwrite_allow,
  input wire logic           log_overwrite_allow,
  input wire logic           ov_raw,
  input wire logic [NCH-1:0] slow_under_irq_enable,
  // Outputs watched
  input wire logic [NCH-1:0] slow_under_irq_gated,
  input wire logic [NCH-1:0] transition_masks,
  input wire logic           ov_filtered,
  input wire logic           self_test_entry,
  input wire logic           reset_out,
  input wire logic           logging_trigger,
  input wire logic           timestamp_release,
  input wire logic [3:0]     log_release
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic wr_rec  = wr_en && addr == ADDR_REC_CTL;
  wire logic wr_ctl  = wr_en && addr == ADDR_CONTROL;
  wire logic start_w = wr_rec && wdata[7];

  a_start_pulse: assert property (
    start_w |=> logging_trigger ##1 !logging_trigger)
    else $error("logging trigger pulse wrong");
  a_no_stray: assert property (
    logging_trigger |-> $past(start_w))
    else $error("logging trigger without write");
  a_bist_pulse: assert property (
    wr_ctl && wdata[7] |=> self_test_entry)
    else $error("self test entry missing");
  a_ts_release: assert property (
    wr_rec && wdata[4] |=>
      timestamp_release == !$past(timestamp_overwrite_allow))
    else $error("timestamp release wrong");
  a_log_release: assert property (
    wr_rec && wdata[3] && !log_overwrite_allow |=> log_release[3])
    else $error("power-up log release missing");
  a_manual_rst: assert property (
    wr_ctl && wdata[5] |-> ##[1:2] reset_out)
    else $error("manual reset not driven");
  a_gate_mask: assert property (
    slow_under_irq_gated == (slow_under_irq_enable & ~transition_masks))
    else $error("gated enable wrong");
  a_cut_read: assert property (
    addr == ADDR_LF_CUTOFF |-> rdata[7:3] == RST_LF_CUTOFF[7:3])
    else $error("cutoff reserved bits set");
  a_rec_read: assert property (
    addr == ADDR_REC_CTL |-> (rdata & 8'h9F) == 8'h00)
    else $error("recording control self-clear bits set");
  a_ov_settle: assert property (
    $rose(ov_filtered) |-> $past(ov_raw) && $past(ov_raw, 4))
    else $error("overvoltage result not settled");
endmodule : msc_regs_sva

bind msc_regs msc_regs_sva #(.NCH(NCH)) u_msc_regs_sva (
  .clk, .rstn, .wr_en, .addr, .wdata, .rdata,
  .timestamp_overwrite_allow, .log_overwrite_allow, .ov_raw,
  .slow_under_irq_enable, .slow_under_irq_gated, .transition_masks,
  .ov_filtered, .self_test_entry, .reset_out, .logging_trigger,
  .timestamp_release, .log_release);

// ==== tb/test_msc_regs.sv ====
// Purpose: Directed bench for the sequence control register bank
// Assumes: Timeout step 10 cycles, reset delays scaled by 1000
// Notes:   Expectations come from the register table only
`timescale 1ns/1ps
module test_msc_regs;
  import msc_pkg::*;
  logic clk = 0, rstn = 0, wr_en = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, m8, g1, g2, g3;
  logic tsa = 0, lga = 0, act = 0, slp = 1, ovr = 0, uvr = 0;
  logic ofa = 0;
  logic [15:0] tmo = 16'h0000;
  logic [7:0] en = 8'hFF, m_x;
  logic ovf, uvf, fft, ste, rso, lgt, tsr;
  logic [2:0] cut, rds;
  logic [3:0] lrel;
  msc_seq_t sel;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  always #10 clk = ~clk;

  msc_regs #(.TOUT_STEP(10), .RDLY_SCALE(1000)) u_msc_regs (
    .clk, .rstn, .wr_en, .addr, .wdata, .rdata,
    .seq_timeout_ms(tmo), .timestamp_overwrite_allow(tsa),
    .log_overwrite_allow(lga), .activate_input(act),
    .sleep_input(slp), .ov_raw(ovr), .uv_raw(uvr),
    .ov_fault_any(ofa), .slow_under_irq_enable(en),
    .fast_under_irq_enable(en), .fast_over_irq_enable(en),
    .slow_under_irq_gated(g1), .fast_under_irq_gated(g2),
    .fast_over_irq_gated(g3), .transition_masks(m8),
    .ov_filtered(ovf), .uv_filtered(uvf), .slow_path_cutoff(cut),
    .fast_fault_to_reset(fft), .self_test_entry(ste),
    .reset_out(rso), .reset_delay_sel(rds), .logging_trigger(lgt),
    .recorded_transition_select(sel), .timestamp_release(tsr),
    .log_release(lrel));

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // ****
  // Scenarios
  // ****
  task automatic t_reset_vals();
    rd(8'h94, 8'h00);
    rd(8'h95, 8'h14);
    rd(8'h9F, 8'h02);
    rd(8'hA0, 8'h00);
    for (int i = 0; i < 4; i++) rd(8'hA1 + 8'(i), 8'hFF);
    wr(8'h96, 8'hFF);
    rd(8'h96, 8'h00);
  endtask : t_reset_vals

  task automatic t_cutoff();
    wr(8'h95, 8'hFE);
    rd(8'h95, 8'h16);
    chk(8'(fft), 8'h01);
    wr(8'h95, 8'h02);
    rd(8'h95, 8'h12);
    chk(8'(cut), 8'h02);
    chk(8'(fft), 8'h01);
    @(posedge clk);
    ofa <= 1'b1;
    @(negedge clk);
    chk(8'(rso), 8'h01);
    @(posedge clk);
    ofa <= 1'b0;
  endtask : t_cutoff

  task automatic t_control();
    wr(8'h9F, 8'hFF);
    @(negedge clk);
    chk(8'(ste), 8'h01);
    wt(1);
    chk(8'(ste), 8'h00);
    rd(8'h9F, 8'h67);
    chk(8'(rds), 8'h07);
    chk(8'(rso), 8'h01);
    wr(8'h9F, 8'h20);
    wr(8'h9F, 8'h00);
    wt(2);
    chk(8'(rso), 8'h01);
    wt(30);
    chk(8'(rso), 8'h00);
  endtask : t_control

  task automatic t_record();
    for (int s = 0; s < 4; s++) begin
      wr(8'hA0, {1'b1, 2'(s), 5'h1F});
      @(negedge clk);
      chk(8'(lgt), 8'h01);
      chk(8'(tsr), 8'h01);
      chk(8'(lrel), 8'h0F);
      chk(8'(sel), 8'(s));
      rd(8'hA0, {1'b0, 2'(s), 5'h00});
    end
    @(posedge clk);
    tsa <= 1'b1;
    lga <= 1'b1;
    wr(8'hA0, 8'h1F);
    @(negedge clk);
    chk({3'h0, tsr, lrel}, 8'h00);
  endtask : t_record

  task automatic t_mask(input logic [7:0] a, input logic [7:0] m,
                        input logic na, input logic ns);
    wr(a, m);
    @(posedge clk);
    act <= na;
    slp <= ns;
    wt(3);
    chk(m8, m);
    chk(g1 & g2 & g3, ~m);
    wt(15);
    chk(m8, 8'h00);
  endtask : t_mask

  // Timeout of 1 gives two steps; check both sides of the release
  task automatic t_timeout();
    @(posedge clk);
    tmo <= 16'h0001;
    wr(8'hA1, 8'h01);
    @(posedge clk);
    act <= 1'b1;
    wt(21);
    chk(m8, 8'h01);
    wt(2);
    chk(m8, 8'h00);
  endtask : t_timeout

  task automatic t_debounce();
    wr(8'h94, 8'h01);
    rd(8'h94, 8'h01);
    @(posedge clk);
    ovr <= 1'b1;
    uvr <= 1'b1;
    wt(3);
    chk(8'(ovf), 8'h00);
    wt(6);
    chk(8'({uvf, ovf}), 8'h01);
    wt(10);
    chk(8'(uvf), 8'h01);
  endtask : t_debounce

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset_vals();
    t_cutoff();
    t_control();
    t_record();
    t_mask(8'hA1, 8'h0F, 1'b1, 1'b1);
    t_mask(8'hA2, 8'hF0, 1'b0, 1'b1);
    t_mask(8'hA4, 8'h81, 1'b0, 1'b0);
    t_mask(8'hA3, 8'h3C, 1'b0, 1'b1);
    t_timeout();
    t_debounce();
    wrap_up();
  end
endmodule : test_msc_regs
